// ==== core/fwp_defines.vh ====
// constants for the flash write-protect and status block
`ifndef FWP_DEFINES_VH
`define FWP_DEFINES_VH

// clock period in ns
`define FWP_CLK_NS 100
// instruction codes
`define FWP_OP_WREN 8'h06
`define FWP_OP_WRDI 8'h04
`define FWP_OP_PP 8'h02
`define FWP_OP_QPP 8'h32
`define FWP_OP_SE 8'h20
`define FWP_OP_BE32 8'h52
`define FWP_OP_BE64 8'hD8
`define FWP_OP_CE 8'hC7
`define FWP_OP_WRSR 8'h01
`define FWP_OP_WRSR2 8'h31
`define FWP_OP_WRSR3 8'h11
`define FWP_OP_ERSCUR 8'h44
`define FWP_OP_PRSCUR 8'h42
`define FWP_OP_RDSR1 8'h05
`define FWP_OP_PD 8'hB9
`define FWP_OP_RPD 8'hAB
`define FWP_OP_UNLOCK 8'h39
`define FWP_OP_LOCK 8'h36
`define FWP_OP_SUSPEND 8'h75
`define FWP_OP_RESUME 8'h7A
`define FWP_OP_PREFIX1 8'hAA
`define FWP_OP_PREFIX2 8'h55
// status_one bit positions
`define FWP_S1_BUSY 0
`define FWP_S1_WEL 1
`define FWP_S1_BP_LO 2
`define FWP_S1_BP_HI 4
`define FWP_S1_TB 5
`define FWP_S1_SEC 6
`define FWP_S1_SRP 7
// status_two bit positions
`define FWP_S2_SRL 0
`define FWP_S2_QE 1
`define FWP_S2_LB_LO 3
`define FWP_S2_LB_HI 5
`define FWP_S2_CMP 6
`define FWP_S2_SUS 7
// status_three bit position of the scheme select
`define FWP_S3_WPS 2
// region lock layout
`define FWP_LOCK_DEPTH 158
`define FWP_LOCK_AW 8
`define FWP_BOT_BASE 8'h7E
`define FWP_TOP_BASE 8'h8E
`define FWP_BOT_BLK 7'h00
`define FWP_TOP_BLK 7'h7F
`define FWP_BLK_CNT 8'h80
`define FWP_SECT_CNT 5'h10
`define FWP_SECT_MAX 5'h08
`define FWP_BP_NONE 3'h0
`define FWP_BP_ALL 3'h7
// prefix sequence stages
`define FWP_PRE_NONE 2'h0
`define FWP_PRE_ONE 2'h1
`define FWP_PRE_TWO 2'h2

`endif

// ==== core/fwp_sync.v ====
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module fwp_sync #(
   parameter W = 4
) (
   input wire clk,
   input wire rst_b,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_q;

   // first stage feeds only the second stage
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // fwp_sync

// ==== core/fwp_lock_mem.v ====
// per-region lock bit store, registered read, set to ones on init
`timescale 1ns/100ps
module fwp_lock_mem #(
   parameter DEPTH = 158,
   parameter AW = 8
) (
   input wire clk,
   input wire rst_b,
   input wire init,
   input wire [AW-1:0] rd_addr,
   output reg rd_q,
   output reg any_q,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire wr_bit
);
   reg [DEPTH-1:0] bits_q;

   // storage: all locked at reset and on init
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bits_q <= {DEPTH{1'b1}};
      end else if (init) begin
         bits_q <= {DEPTH{1'b1}};
      end else if (wr_en && wr_addr < DEPTH) begin
         bits_q[wr_addr] <= wr_bit;
      end
   end

   // registered read and any-locked summary
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_q <= 1'b1;
         any_q <= 1'b1;
      end else begin
         rd_q <= (rd_addr < DEPTH) ? bits_q[rd_addr] : 1'b1;
         any_q <= |bits_q;
      end
   end
endmodule // fwp_lock_mem

// ==== core/fwp_core.v ====
// write-protect and status logic of the serial flash
//
// Operation
// R1 - supply low: hold reset, ignore instructions
// R2 - reject writes until power-up delay elapses
// R3 - write enable latch clear after power-up
// R4 - modify instructions need write enable latch
// R5 - write enable sets latch bit S1
// R6 - latch cleared by disable, program, erase, status
// R7 - busy S0 during operation, only status/suspend
// R8 - power-down ignores all but release
// R9 - 126 block plus 32 sector lock bits
// R10 - locked region refuses erase and program
// R11 - locks set at power-on, 39h unlocks
// R12 - scheme select picks field or lock bits
// R13 - block-protect field S4..S2, default none
// R14 - top/bottom select: 0 top, 1 bottom
// R15 - granularity: 1 sectors, 0 blocks
// R16 - complement bit S14 inverts protected range
// R17 - status-protect S7 and status-lock S8 held
// R18 - both zero: pin ignored, latch suffices
// R19 - protect set: low pin blocks status writes
// R20 - status lock refuses writes until power cycle
// R21 - AAh 55h prefix makes status permanent
// R22 - pin consulted only outside quad operation
// R23 - power cycle clears status lock
// R24 - locks set to ones after reset too
// R25 - rejected write changes nothing, no busy
`timescale 1ns/100ps
`include "fwp_defines.vh"
module fwp_core #(
   parameter PUW_US = 10,
   parameter PUW_W = 16
) (
   input wire CLOCK,
   input wire RST_B,
   input wire VCC_OK,
   input wire SCK,
   input wire CS_B,
   input wire WP_B,
   input wire QUAD_MODE,
   input wire [7:0] INSTR_OP,
   input wire [22:0] INSTR_ADDR,
   input wire [15:0] INSTR_DATA,
   input wire OP_DONE,
   output reg OP_START,
   output reg [7:0] OP_CODE,
   output reg [22:0] OP_ADDR,
   output reg OP_REJECT,
   output wire [7:0] STATUS_ONE,
   output wire [7:0] STATUS_TWO,
   output wire [7:0] STATUS_THREE
);
   localparam integer PUW_CYC_I =
      (PUW_US * 1000 + `FWP_CLK_NS - 1) / `FWP_CLK_NS;
   localparam [PUW_W-1:0] PUW_CYC = PUW_CYC_I[PUW_W-1:0];
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_LOOK = 2'b01;
   localparam [1:0] ST_DECIDE = 2'b10;

   wire vcc_s;
   wire sck_s;
   wire cs_s;
   wire sel_s;
   wire wp_s;
   reg sck_d_q;
   reg cs_d_q;
   reg [2:0] bit_q;
   reg seen_q;
   reg [PUW_W-1:0] puw_cnt_q;
   reg puw_done_q;
   reg [1:0] state_q;
   reg [7:0] op_q;
   reg [22:0] addr_q;
   reg [15:0] data_q;
   reg good_q;
   reg wel_q;
   reg busy_q;
   reg sus_q;
   reg pd_q;
   reg [2:0] bp_q;
   reg tb_q;
   reg sec_q;
   reg srp_q;
   reg srl_q;
   reg qe_q;
   reg [2:0] lb_q;
   reg cmp_q;
   reg wps_q;
   reg otp_q;
   reg [1:0] pre_q;
   reg lk_we_q;
   reg lk_bit_q;
   reg [7:0] lk_addr_q;
   wire lock_rd;
   wire lock_any;
   wire frame_end;
   wire sck_rise;
   wire [7:0] region;
   reg is_mod;
   reg is_ce;
   reg is_scr;
   reg is_wsr;
   reg bp_prot;
   reg arr_prot;
   reg wsr_ok;
   reg sec_prot;
   reg prot;

   // region index: middle blocks first, then bottom and top sectors
   function [7:0] fwp_region;
      input [22:0] a;
      begin
         if (a[22:16] == `FWP_BOT_BLK)
            fwp_region = `FWP_BOT_BASE + {4'h0, a[15:12]};
         else if (a[22:16] == `FWP_TOP_BLK)
            fwp_region = `FWP_TOP_BASE + {4'h0, a[15:12]};
         else
            fwp_region = {1'b0, a[22:16]} - 8'h01;
      end
   endfunction

   // block-protect field hit for one address, before complement
   function fwp_bp_hit;
      input [22:0] a;
      input [2:0] bp;
      input tb;
      input sec;
      reg [7:0] n;
      reg [4:0] s;
      begin
         n = 8'h01 << bp;
         s = (bp >= 3'h4) ? `FWP_SECT_MAX : (5'h01 << (bp - 3'h1));
         if (bp == `FWP_BP_NONE)
            fwp_bp_hit = 1'b0;
         else if (bp == `FWP_BP_ALL)
            fwp_bp_hit = 1'b1;
         else if (!sec)
            fwp_bp_hit = tb ? ({1'b0, a[22:16]} < n) :
               ({1'b0, a[22:16]} >= (`FWP_BLK_CNT - n));
         else if (tb)
            fwp_bp_hit = (a[22:16] == `FWP_BOT_BLK) &&
               ({1'b0, a[15:12]} < s);
         else
            fwp_bp_hit = (a[22:16] == `FWP_TOP_BLK) &&
               ({1'b0, a[15:12]} >= (`FWP_SECT_CNT - s));
      end
   endfunction

   // pins from outside the clock domain
   fwp_sync #(
      .W(4)
   ) u_sync (
      .clk(CLOCK),
      .rst_b(RST_B),
      .d({VCC_OK, SCK, ~CS_B, WP_B}),
      .q({vcc_s, sck_s, sel_s, wp_s})
   );

   // select synced high-active so reset shows it deselected, no false end
   assign cs_s = ~sel_s;

   // lock bits, reloaded to ones whenever the supply is low
   fwp_lock_mem #(
      .DEPTH(`FWP_LOCK_DEPTH),
      .AW(`FWP_LOCK_AW)
   ) u_lock (
      .clk(CLOCK),
      .rst_b(RST_B),
      .init(~vcc_s), // R11 R24
      .rd_addr(region),
      .rd_q(lock_rd),
      .any_q(lock_any),
      .wr_en(lk_we_q),
      .wr_addr(lk_addr_q),
      .wr_bit(lk_bit_q)
   ); // R9

   assign region = fwp_region(addr_q);
   assign frame_end = cs_s & ~cs_d_q;
   assign sck_rise = sck_s & ~sck_d_q & ~cs_s;

   // serial frame tracking: count clock edges per chip-select frame
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         sck_d_q <= 1'b0;
         cs_d_q <= 1'b1;
         bit_q <= 3'h0;
         seen_q <= 1'b0;
      end else begin
         sck_d_q <= sck_s;
         cs_d_q <= cs_s;
         if (cs_s) begin
            bit_q <= 3'h0;
            seen_q <= 1'b0;
         end else if (sck_rise) begin
            bit_q <= bit_q + 3'h1;
            seen_q <= 1'b1;
         end
      end
   end

   // power-up write delay, restarted while the supply is low
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         puw_cnt_q <= {PUW_W{1'b0}};
         puw_done_q <= 1'b0;
      end else if (!vcc_s) begin
         puw_cnt_q <= {PUW_W{1'b0}}; // R2
         puw_done_q <= 1'b0;
      end else if (!puw_done_q) begin
         puw_cnt_q <= puw_cnt_q + {{(PUW_W-1){1'b0}}, 1'b1};
         puw_done_q <= (puw_cnt_q + {{(PUW_W-1){1'b0}}, 1'b1}) >= PUW_CYC;
      end
   end

   // instruction classes and protection checks
   always @* begin
      is_mod = (op_q == `FWP_OP_PP) || (op_q == `FWP_OP_QPP) ||
         (op_q == `FWP_OP_SE) || (op_q == `FWP_OP_BE32) ||
         (op_q == `FWP_OP_BE64);
      is_ce = (op_q == `FWP_OP_CE);
      is_scr = (op_q == `FWP_OP_ERSCUR) || (op_q == `FWP_OP_PRSCUR);
      is_wsr = (op_q == `FWP_OP_WRSR) || (op_q == `FWP_OP_WRSR2) ||
         (op_q == `FWP_OP_WRSR3);
      bp_prot = fwp_bp_hit(addr_q, bp_q, tb_q, sec_q) ^ // R13 R14 R15
         cmp_q; // R16
      arr_prot = wps_q ? lock_rd : bp_prot; // R10 R12
      sec_prot = (addr_q[13:12] != 2'h0) &&
         lb_q[addr_q[13:12] - 2'h1];
      // status write gate; pin only counts outside quad operation
      wsr_ok = ~otp_q & ~srl_q & // R20 R21
         ~(srp_q & ~QUAD_MODE & ~wp_s); // R18 R19 R22
      prot = 1'b0;
      if (is_mod)
         prot = arr_prot;
      else if (is_ce)
         prot = wps_q ? lock_any :
            ~(((bp_q == `FWP_BP_NONE) && !cmp_q) ||
            ((bp_q == `FWP_BP_ALL) && cmp_q)); // R12
      else if (is_scr)
         prot = sec_prot;
      else if (is_wsr)
         prot = ~wsr_ok;
   end

   // control: frame capture, decision, status register updates
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= ST_IDLE;
         op_q <= 8'h00;
         addr_q <= 23'h000000;
         data_q <= 16'h0000;
         good_q <= 1'b0;
         wel_q <= 1'b0; // R3
         busy_q <= 1'b0;
         sus_q <= 1'b0;
         pd_q <= 1'b0;
         bp_q <= `FWP_BP_NONE;
         tb_q <= 1'b0;
         sec_q <= 1'b0;
         srp_q <= 1'b0;
         srl_q <= 1'b0;
         qe_q <= 1'b0;
         lb_q <= 3'h0;
         cmp_q <= 1'b0;
         wps_q <= 1'b0;
         otp_q <= 1'b0;
         pre_q <= `FWP_PRE_NONE;
         lk_we_q <= 1'b0;
         lk_bit_q <= 1'b0;
         lk_addr_q <= 8'h00;
         OP_START <= 1'b0;
         OP_CODE <= 8'h00;
         OP_ADDR <= 23'h000000;
         OP_REJECT <= 1'b0;
      end else begin
         OP_START <= 1'b0;
         OP_REJECT <= 1'b0;
         lk_we_q <= 1'b0;
         if (!vcc_s) begin
            // supply below threshold: everything held off
            state_q <= ST_IDLE; // R1
            wel_q <= 1'b0; // R3
            busy_q <= 1'b0;
            sus_q <= 1'b0;
            pd_q <= 1'b0;
            srl_q <= 1'b0; // R23
            pre_q <= `FWP_PRE_NONE;
         end else begin
            // engine reports the running operation finished
            if (OP_DONE && busy_q) begin
               busy_q <= 1'b0; // R7
               wel_q <= 1'b0; // R6
            end
            case (state_q)
               ST_IDLE: begin
                  if (frame_end) begin
                     op_q <= INSTR_OP;
                     addr_q <= INSTR_ADDR;
                     data_q <= INSTR_DATA;
                     good_q <= seen_q && (bit_q == 3'h0);
                     state_q <= ST_LOOK;
                  end
               end
               ST_LOOK: begin
                  state_q <= ST_DECIDE; // lock bit read settles
               end
               ST_DECIDE: begin
                  state_q <= ST_IDLE;
                  if (!good_q) begin
                     pre_q <= pre_q; // partial byte: no effect
                  end else if (pd_q) begin
                     if (op_q == `FWP_OP_RPD)
                        pd_q <= 1'b0; // R8
                  end else if (busy_q) begin
                     // only status read and suspend get through
                     if (op_q == `FWP_OP_SUSPEND && !sus_q) begin
                        sus_q <= 1'b1; // R7
                        busy_q <= 1'b0;
                        OP_START <= 1'b1;
                        OP_CODE <= op_q;
                     end
                  end else begin
                     if (op_q == `FWP_OP_PREFIX1)
                        pre_q <= `FWP_PRE_ONE;
                     else if (op_q == `FWP_OP_PREFIX2 &&
                        pre_q == `FWP_PRE_ONE)
                        pre_q <= `FWP_PRE_TWO;
                     else
                        pre_q <= `FWP_PRE_NONE;
                     if (op_q == `FWP_OP_RESUME && sus_q) begin
                        sus_q <= 1'b0;
                        busy_q <= 1'b1;
                        OP_START <= 1'b1;
                        OP_CODE <= op_q;
                     end else if (op_q == `FWP_OP_WREN) begin
                        if (puw_done_q)
                           wel_q <= 1'b1; // R2 R5
                     end else if (op_q == `FWP_OP_WRDI) begin
                        wel_q <= 1'b0; // R6
                     end else if (op_q == `FWP_OP_PD) begin
                        pd_q <= 1'b1; // R8
                     end else if (op_q == `FWP_OP_UNLOCK ||
                        op_q == `FWP_OP_LOCK) begin
                        if (wel_q && puw_done_q) begin
                           lk_we_q <= 1'b1; // R11
                           lk_addr_q <= region;
                           lk_bit_q <= (op_q == `FWP_OP_LOCK);
                           wel_q <= 1'b0;
                        end
                     end else if (is_mod || is_ce || is_scr || is_wsr) begin
                        if (!puw_done_q || !wel_q || prot) begin
                           OP_REJECT <= 1'b1; // R2 R4 R25
                        end else begin
                           wel_q <= 1'b0; // R6
                           busy_q <= 1'b1; // R7
                           OP_START <= 1'b1;
                           OP_CODE <= op_q;
                           OP_ADDR <= addr_q;
                           if (is_wsr && pre_q == `FWP_PRE_TWO)
                              otp_q <= 1'b1; // R21
                           if (op_q == `FWP_OP_WRSR) begin
                              bp_q <= data_q[`FWP_S1_BP_HI:`FWP_S1_BP_LO];
                              tb_q <= data_q[`FWP_S1_TB];
                              sec_q <= data_q[`FWP_S1_SEC];
                              srp_q <= data_q[`FWP_S1_SRP]; // R17
                           end
                           if (op_q == `FWP_OP_WRSR ||
                              op_q == `FWP_OP_WRSR2) begin
                              // status_two: second byte of the wide write, or the only byte of WRSR2
                              if (op_q == `FWP_OP_WRSR) begin
                                 srl_q <= data_q[8 + `FWP_S2_SRL]; // R17
                                 qe_q <= QUAD_MODE |
                                    data_q[8 + `FWP_S2_QE];
                                 lb_q <= lb_q | data_q[8 +
                                    `FWP_S2_LB_HI:8 + `FWP_S2_LB_LO];
                                 cmp_q <= data_q[8 + `FWP_S2_CMP];
                              end else begin
                                 srl_q <= data_q[`FWP_S2_SRL];
                                 qe_q <= QUAD_MODE | data_q[`FWP_S2_QE];
                                 lb_q <= lb_q |
                                    data_q[`FWP_S2_LB_HI:`FWP_S2_LB_LO];
                                 cmp_q <= data_q[`FWP_S2_CMP];
                              end
                           end
                           if (op_q == `FWP_OP_WRSR3)
                              wps_q <= data_q[`FWP_S3_WPS]; // R12
                        end
                     end
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // status registers as seen by the read-status instructions
   assign STATUS_ONE = {srp_q, sec_q, tb_q, bp_q, wel_q, busy_q}; // R5 R7
   assign STATUS_TWO = {sus_q, cmp_q, lb_q, 1'b0, qe_q, srl_q};
   assign STATUS_THREE = {5'h00, wps_q, 2'h0};

endmodule // fwp_core

// ==== verif/fwp_core_chk.sv ====
// port checker for the write-protect and status block
`timescale 1ns/100ps
`include "fwp_defines.vh"
module fwp_core_chk #(
   parameter PUW_US = 10,
   parameter PUW_W = 16
) (
   input wire CLOCK,
   input wire RST_B,
   input wire VCC_OK,
   input wire SCK,
   input wire CS_B,
   input wire WP_B,
   input wire QUAD_MODE,
   input wire [7:0] INSTR_OP,
   input wire [22:0] INSTR_ADDR,
   input wire [15:0] INSTR_DATA,
   input wire OP_DONE,
   input wire OP_START,
   input wire [7:0] OP_CODE,
   input wire [22:0] OP_ADDR,
   input wire OP_REJECT,
   input wire [7:0] STATUS_ONE,
   input wire [7:0] STATUS_TWO,
   input wire [7:0] STATUS_THREE
);
   logic [15:0] up_q;
   wire write_enable_latch = STATUS_ONE[`FWP_S1_WEL];
   wire busy = STATUS_ONE[`FWP_S1_BUSY];
   wire status_lock = STATUS_TWO[`FWP_S2_SRL];
   wire wrsr = OP_CODE == `FWP_OP_WRSR || OP_CODE == `FWP_OP_WRSR2 ||
      OP_CODE == `FWP_OP_WRSR3;
   wire mod_op = OP_CODE != `FWP_OP_SUSPEND && OP_CODE != `FWP_OP_RESUME;
   // cycles since supply came up, saturating; never shorter than design's
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         up_q <= 16'h0000;
      end else if (!VCC_OK) begin
         up_q <= 16'h0000;
      end else if (up_q != 16'hFFFF) begin
         up_q <= up_q + 16'h0001;
      end
   end
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_B);
   // properties on decisions and status
   property p_rst;
      $rose(RST_B) |-> {STATUS_THREE, STATUS_TWO, STATUS_ONE} == 24'h000000;
   endproperty
   a_rst: assert property (p_rst) else $error("reset status");
   property p_delay; $rose(write_enable_latch) |-> up_q >= PUW_US * 10; endproperty
   a_delay: assert property (p_delay) else $error("latch inside delay");
   property p_wel; OP_START && mod_op |-> $past(write_enable_latch); endproperty
   a_wel: assert property (p_wel) else $error("start without latch");
   property p_busy; OP_START && mod_op |-> busy && !write_enable_latch; endproperty
   a_busy: assert property (p_busy) else $error("start status");
   property p_done; OP_DONE && busy |=> !busy; endproperty
   a_done: assert property (p_done) else $error("busy after done");
   property p_rej;
      OP_REJECT |-> !OP_START && $stable(STATUS_ONE) &&
         $stable(STATUS_TWO) && $stable(STATUS_THREE);
   endproperty
   a_rej: assert property (p_rej) else $error("refusal changed state");
   property p_pulse; OP_START || OP_REJECT |=> !OP_START && !OP_REJECT;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse too long");
   property p_low; !VCC_OK [*5] |-> !write_enable_latch && !busy && !status_lock; endproperty
   a_low: assert property (p_low) else $error("low supply");
   property p_quiet; !VCC_OK [*8] |-> !OP_START && !OP_REJECT; endproperty
   a_quiet: assert property (p_quiet) else $error("low supply pulse");
   property p_srl; OP_START && $past(status_lock) |-> !wrsr; endproperty
   a_srl: assert property (p_srl) else $error("write under lock");
endmodule // fwp_core_chk

bind fwp_core fwp_core_chk #(.PUW_US(PUW_US), .PUW_W(PUW_W)) fwp_core_chk_i (
   .CLOCK(CLOCK), .RST_B(RST_B), .VCC_OK(VCC_OK), .SCK(SCK), .CS_B(CS_B),
   .WP_B(WP_B), .QUAD_MODE(QUAD_MODE), .INSTR_OP(INSTR_OP),
   .INSTR_ADDR(INSTR_ADDR), .INSTR_DATA(INSTR_DATA), .OP_DONE(OP_DONE),
   .OP_START(OP_START), .OP_CODE(OP_CODE), .OP_ADDR(OP_ADDR),
   .OP_REJECT(OP_REJECT), .STATUS_ONE(STATUS_ONE),
   .STATUS_TWO(STATUS_TWO), .STATUS_THREE(STATUS_THREE));

// ==== verif/fwp_host.sv ====
// serial host model sending one-byte instruction frames
`timescale 1ns/100ps
module fwp_host (
   input wire clk,
   output logic sck,
   output logic cs_b,
   output logic [7:0] op,
   output logic [22:0] addr,
   output logic [15:0] data
);
   // idle bus: link clock low, chip deselected
   initial begin
      sck = 1'b0;
      cs_b = 1'b1;
      op = 8'h00;
      addr = 23'h000000;
      data = 16'h0000;
   end
   // mode 0 frame, eight link clocks of 800 ns; clock still outside frames
   task automatic frame(input logic [7:0] o, input logic [22:0] a,
      input logic [15:0] d);
      begin
         @(negedge clk);
         op = o;
         addr = a;
         data = d;
         cs_b = 1'b0;
         repeat (4) @(negedge clk);
         repeat (8) begin
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
            repeat (4) @(negedge clk);
         end
         cs_b = 1'b1;
         // hold decoded values until decided, then show stale-proof values
         repeat (8) @(negedge clk);
         op = ~o;
         addr = ~a;
         data = ~d;
      end
   endtask
endmodule // fwp_host

// ==== verif/tb_flash_write_protect_status.sv ====
// self-checking bench of the write-protect and status block
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
   begin \
      total_checks = total_checks + 1; \
      if ((gt) !== (ex)) begin \
         errors = errors + 1; \
         $display("unexpected %s exp %h got %h", nm, ex, gt); \
      end \
   end
module tb_flash_write_protect_status;
   localparam int PUW_US = 20;
   localparam int UP_WAIT = PUW_US * 10 + 20;
   localparam int LIMIT = 20000;
   // f: power cycle, wp pin, quad, enable first, done; r: start, refuse
   typedef struct packed {
      logic [4:0] f;
      logic [7:0] op;
      logic [10:0] a;
      logic [15:0] d;
      logic [23:0] s;
      logic [1:0] r;
   } fwp_row_t;
   logic CLOCK = 1'b0;
   logic RST_B = 1'b0;
   logic VCC_OK = 1'b1;
   logic WP_B = 1'b1;
   logic QUAD_MODE = 1'b0;
   logic OP_DONE = 1'b0;
   logic clr = 1'b0;
   logic [1:0] seen;
   wire SCK, CS_B, OP_START, OP_REJECT;
   wire [7:0] INSTR_OP, OP_CODE, STATUS_ONE, STATUS_TWO, STATUS_THREE;
   wire [22:0] INSTR_ADDR, OP_ADDR;
   wire [15:0] INSTR_DATA;
   int errors = 0;
   int total_checks = 0;
   int cyc = 0;
   fwp_row_t rows [49] = '{
      '{5'h08,8'h02,11'h000,16'h0000,24'h000000,2'h1},
      '{5'h08,8'h06,11'h000,16'h0000,24'h000002,2'h0},
      '{5'h08,8'h04,11'h000,16'h0000,24'h000000,2'h0},
      '{5'h0B,8'h02,11'h000,16'h0000,24'h000000,2'h2},
      '{5'h0B,8'h01,11'h000,16'h0004,24'h000004,2'h2},
      '{5'h0A,8'h20,11'h7F0,16'h0000,24'h000006,2'h1},
      '{5'h09,8'h20,11'h000,16'h0000,24'h000004,2'h2},
      '{5'h0B,8'h01,11'h000,16'h0024,24'h000024,2'h2},
      '{5'h0A,8'h20,11'h000,16'h0000,24'h000026,2'h1},
      '{5'h09,8'h20,11'h7F0,16'h0000,24'h000024,2'h2},
      '{5'h0B,8'h01,11'h000,16'h4024,24'h004024,2'h2},
      '{5'h0A,8'h20,11'h7F0,16'h0000,24'h004026,2'h1},
      '{5'h09,8'h20,11'h000,16'h0000,24'h004024,2'h2},
      '{5'h0B,8'h01,11'h000,16'h0064,24'h000064,2'h2},
      '{5'h0A,8'h20,11'h000,16'h0000,24'h000066,2'h1},
      '{5'h09,8'h20,11'h001,16'h0000,24'h000064,2'h2},
      '{5'h0B,8'h01,11'h000,16'h0000,24'h000000,2'h2},
      '{5'h0B,8'h42,11'h001,16'h0000,24'h000000,2'h2},
      '{5'h0B,8'h11,11'h000,16'h0004,24'h040000,2'h2},
      '{5'h0A,8'h02,11'h100,16'h0000,24'h040002,2'h1},
      '{5'h08,8'h39,11'h100,16'h0000,24'h040000,2'h0},
      '{5'h0B,8'h02,11'h100,16'h0000,24'h040000,2'h2},
      '{5'h0A,8'h02,11'h200,16'h0000,24'h040002,2'h1},
      '{5'h0B,8'h01,11'h000,16'h001C,24'h04001C,2'h2},
      '{5'h0B,8'h02,11'h100,16'h0000,24'h04001C,2'h2},
      '{5'h0A,8'h36,11'h100,16'h0000,24'h04001C,2'h0},
      '{5'h0A,8'h02,11'h100,16'h0000,24'h04001E,2'h1},
      '{5'h0B,8'h01,11'h000,16'h0000,24'h040000,2'h2},
      '{5'h0A,8'hC7,11'h000,16'h0000,24'h040002,2'h1},
      '{5'h08,8'hB9,11'h000,16'h0000,24'h040002,2'h0},
      '{5'h08,8'h04,11'h000,16'h0000,24'h040002,2'h0},
      '{5'h08,8'hAB,11'h000,16'h0000,24'h040002,2'h0},
      '{5'h08,8'h04,11'h000,16'h0000,24'h040000,2'h0},
      '{5'h0B,8'h01,11'h000,16'h0080,24'h040080,2'h2},
      '{5'h02,8'h01,11'h000,16'h0084,24'h040082,2'h1},
      '{5'h07,8'h01,11'h000,16'h0080,24'h040280,2'h2},
      '{5'h0B,8'h01,11'h000,16'h0100,24'h040100,2'h2},
      '{5'h0A,8'h01,11'h000,16'h0000,24'h040102,2'h1},
      '{5'h1A,8'h02,11'h100,16'h0000,24'h040002,2'h1},
      '{5'h0B,8'h11,11'h000,16'h0000,24'h000000,2'h2},
      '{5'h0A,8'h02,11'h000,16'h0000,24'h000001,2'h2},
      '{5'h08,8'h75,11'h000,16'h0000,24'h008000,2'h2},
      '{5'h08,8'h7A,11'h000,16'h0000,24'h000001,2'h2},
      '{5'h09,8'h06,11'h000,16'h0000,24'h000000,2'h0},
      '{5'h08,8'h06,11'h000,16'h0000,24'h000002,2'h0},
      '{5'h08,8'hAA,11'h000,16'h0000,24'h000002,2'h0},
      '{5'h08,8'h55,11'h000,16'h0000,24'h000002,2'h0},
      '{5'h09,8'h01,11'h000,16'h0000,24'h000000,2'h2},
      '{5'h1B,8'h01,11'h000,16'h0004,24'h000002,2'h1}
   };
   fwp_core #(.PUW_US(PUW_US), .PUW_W(16)) fwp_core_i (.CLOCK(CLOCK),
      .RST_B(RST_B), .VCC_OK(VCC_OK), .SCK(SCK), .CS_B(CS_B), .WP_B(WP_B),
      .QUAD_MODE(QUAD_MODE), .INSTR_OP(INSTR_OP), .INSTR_ADDR(INSTR_ADDR),
      .INSTR_DATA(INSTR_DATA), .OP_DONE(OP_DONE), .OP_START(OP_START),
      .OP_CODE(OP_CODE), .OP_ADDR(OP_ADDR), .OP_REJECT(OP_REJECT),
      .STATUS_ONE(STATUS_ONE), .STATUS_TWO(STATUS_TWO),
      .STATUS_THREE(STATUS_THREE));
   fwp_host fwp_host_i (.clk(CLOCK), .sck(SCK), .cs_b(CS_B), .op(INSTR_OP),
      .addr(INSTR_ADDR), .data(INSTR_DATA));
   // clock, sticky record of decision pulses, hang guard
   always #50 CLOCK = ~CLOCK;
   always @(posedge CLOCK) begin
      seen <= clr ? 2'b00 : (seen | {OP_START, OP_REJECT});
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors = errors + 1;
         give_verdict();
      end
   end
   task automatic give_verdict;
      begin
         if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task automatic do_reset;
      begin
         RST_B = 1'b0;
         repeat (6) @(negedge CLOCK);
         RST_B = 1'b1;
      end
   endtask
   // one case: optional supply cycle and enable, instruction, done, status
   task automatic run(input fwp_row_t w);
      begin
         if (w.f[4]) begin
            VCC_OK = 1'b0;
            repeat (10) @(negedge CLOCK);
            VCC_OK = 1'b1;
            repeat (UP_WAIT) @(negedge CLOCK);
         end
         WP_B = w.f[3];
         QUAD_MODE = w.f[2];
         if (w.f[1]) fwp_host_i.frame(8'h06, 23'h000000, 16'h0000);
         @(negedge CLOCK);
         clr = 1'b1;
         @(negedge CLOCK);
         clr = 1'b0;
         fwp_host_i.frame(w.op, {w.a, 12'h000}, w.d);
         repeat (2) @(negedge CLOCK);
         `CHK("decision", w.r, seen)
         if (w.r[1]) begin
            `CHK("op code", w.op, OP_CODE)
            `CHK("op addr", {w.a, 12'h000}, OP_ADDR)
         end
         if (w.f[0]) begin
            OP_DONE = 1'b1;
            @(negedge CLOCK);
            OP_DONE = 1'b0;
         end
         repeat (2) @(negedge CLOCK);
         `CHK("status", w.s, {STATUS_THREE, STATUS_TWO, STATUS_ONE})
      end
   endtask
   // power-up delay first, then table, then mid-run reset by hand
   initial begin
      do_reset();
      run(fwp_row_t'{5'h08,8'h06,11'h000,16'h0,24'h000000,2'h0});
      repeat (UP_WAIT) @(negedge CLOCK);
      foreach (rows[i]) run(rows[i]);
      do_reset();
      @(negedge CLOCK);
      `CHK("reset", 24'h000000, {STATUS_THREE, STATUS_TWO, STATUS_ONE})
      repeat (UP_WAIT) @(negedge CLOCK);
      run(fwp_row_t'{5'h0B,8'h11,11'h000,16'h4,24'h040000,2'h2});
      run(fwp_row_t'{5'h0A,8'h02,11'h000,16'h0,24'h040002,2'h1});
      give_verdict();
   end
endmodule // tb_flash_write_protect_status
